// file: adc_cfg_pkg.sv
// Constants, types and field layout of the configuration register block
// Notes on behaviour
// - One eight-bit register, four enables, one flag.
// - Register reached only by 16-bit serial instructions.
// - Bit 4 appends status bits; resets 0.
// - Bit 3 enables span compression; resets 0.
// - Bit 2 enables high-impedance input; resets 0.
// - Bit 1 enables relaxed readout; resets 0.
// - Bit 0 read-only overvoltage indicator; resets 1.
// - Event state held until read after event.
// - Writes ignore reserved bits and overvoltage indicator.
// - Truncated status readout still converts correctly.
// - Command byte: 0, read/write, then 010100.
// - Write sampled on rising edges, applied after byte.
// - Read shifts register out MSB first, falling edges.
// - Six status bits follow result, MSB first.
package adc_cfg_pkg;

    localparam logic [7:0] CFG_RESET = 8'h01;
    localparam int BIT_STATUS_EN = 4;
    localparam int BIT_SPAN_EN = 3;
    localparam int BIT_HIZ_EN = 2;
    localparam int BIT_RELAXED_EN = 1;
    localparam int BIT_OV_IDLE = 0;
    localparam logic [5:0] CMD_PATTERN = 6'h14;
    localparam logic CMD_REQUEST = 1'b0;
    localparam logic CMD_READ = 1'b1;
    localparam int RESULT_BITS = 16;
    localparam int STATUS_BITS = 6;
    localparam int FIFO_WORDS = 4;
    localparam logic [4:0] CMD_LAST_RISE = 5'h07;
    localparam logic [4:0] DATA_LAST_RISE = 5'h0F;
    localparam logic [4:0] LEN_PLAIN = 5'h10;
    localparam logic [4:0] LEN_STATUS = 5'h16;
    localparam logic [4:0] LEN_REG_FRAME = 5'h10;

    typedef struct packed {
        logic [2:0] reserved;
        logic statusEn;
        logic spanEn;
        logic hiZEn;
        logic relaxedEn;
        logic ovIdle;
    } cfg_t;

    typedef struct packed {
        logic sck;
        logic conversion_start_select;
        logic sdi;
        logic ov;
    } pins_t;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_CMD = 2'b01,
        PH_WRITE = 2'b10,
        PH_SKIP = 2'b11
    } phase_t;

endpackage : adc_cfg_pkg

// file: result_fifo.sv
// Small result FIFO with registered read data and registered ready
`timescale 1ns/1ps
module result_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4
) (
    input wire logic core_clk, // Block clock
    input wire logic sys_rst, // Asynchronous reset, active high
    input wire logic [WIDTH-1:0] inData, // Word to store
    input wire logic inValid, // Word offered
    output logic inReady, // Room for a word
    output logic [WIDTH-1:0] outData, // Oldest word
    output logic outValid, // Oldest word present
    input wire logic outReady // Oldest word taken
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wrPtr;
        logic [PW-1:0] rdPtr;
        logic [CW-1:0] count;
        logic inReady;
        logic outValid;
        logic [WIDTH-1:0] outData;
    } fifo_t;

    fifo_t q;
    fifo_t d;

    always_comb begin
        logic push;
        logic pop;
        push = inValid & q.inReady;
        pop = outReady & q.outValid;
        d = q;
        if (push) begin
            d.mem[q.wrPtr] = inData;
            d.wrPtr = (q.wrPtr == PW'(DEPTH - 1)) ? '0 : q.wrPtr + 1'b1;
        end
        if (pop) begin
            d.rdPtr = (q.rdPtr == PW'(DEPTH - 1)) ? '0 : q.rdPtr + 1'b1;
        end
        if (push && !pop) begin
            d.count = q.count + 1'b1;
        end else if (pop && !push) begin
            d.count = q.count - 1'b1;
        end
        d.inReady = d.count != CW'(DEPTH);
        d.outValid = d.count != '0;
        d.outData = d.mem[d.rdPtr];
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
            q.inReady <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign inReady = q.inReady;
    assign outData = q.outData;
    assign outValid = q.outValid;

endmodule : result_fifo

// file: adc_config_register_sck_budget.sv
// Serial configuration register with result readout and status append
`timescale 1ns/1ps
module adc_config_register_sck_budget import adc_cfg_pkg::*; #(
    parameter int RESULT_W = RESULT_BITS,
    parameter int DEPTH = FIFO_WORDS
) (
    input wire logic core_clk, // Block clock, 40 MHz
    input wire logic sys_rst, // Asynchronous reset, active high
    input wire logic serialClock, // Host serial clock pin, idles low
    input wire logic conversionStartSelect, // Frame select pin, low opens a frame
    input wire logic serialDataIn, // Host data pin
    input wire logic overvoltageEvent, // Clamp active level
    input wire logic [RESULT_W-1:0] resultData, // Conversion result word
    input wire logic resultValid, // Result word offered
    output logic resultReady, // Result buffer has room
    output logic serialDataOut, // Data pin value
    output logic serialDataOutOe_n, // Data pin enable, low while driving
    output logic statusEnable, // Status append enabled
    output logic spanCompression, // Span compression enabled
    output logic highImpedance, // High-impedance input enabled
    output logic relaxedReadout, // Relaxed readout enabled
    output logic overvoltageIndicator // Indicator, 0 after an event
);
    localparam int SH_W = RESULT_W + STATUS_BITS + 2;

    typedef struct packed {
        pins_t meta;
        pins_t sync;
        logic sckPrev;
        logic cnvPrev;
        cfg_t cfg;
        phase_t phase;
        logic [4:0] riseCnt;
        logic [4:0] fallCnt;
        logic [4:0] outLen;
        logic [7:0] cmdSh;
        logic [7:0] wrSh;
        logic [SH_W-1:0] outSh;
        logic drive;
        logic clearPending;
        logic sdo;
        logic oeN;
    } ctl_t;

    ctl_t q;
    ctl_t d;
    logic [RESULT_W-1:0] headData;
    logic headValid;
    logic popHead;
    logic sckRise;
    logic sckFall;
    logic cnvFall;
    logic cnvRise;
    logic [7:0] cmdByte;
    logic [7:0] wrByte;
    logic cmdMatch;
    logic rdDecode;
    logic wrDone;
    logic [STATUS_BITS-1:0] statusWord;

    result_fifo #(
        .WIDTH(RESULT_W),
        .DEPTH(DEPTH)
    ) u_results (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .inData(resultData),
        .inValid(resultValid),
        .inReady(resultReady),
        .outData(headData),
        .outValid(headValid),
        .outReady(popHead)
    );

    always_comb begin
        sckRise = q.sync.sck & ~q.sckPrev;
        sckFall = ~q.sync.sck & q.sckPrev;
        cnvFall = ~q.sync.conversion_start_select & q.cnvPrev;
        cnvRise = q.sync.conversion_start_select & ~q.cnvPrev;
        cmdByte = {q.cmdSh[6:0], q.sync.sdi};
        wrByte = {q.wrSh[6:0], q.sync.sdi};
        cmdMatch = (cmdByte[7] == CMD_REQUEST) && (cmdByte[5:0] == CMD_PATTERN);
        rdDecode = !q.sync.conversion_start_select && sckRise && q.phase == PH_CMD && q.riseCnt == CMD_LAST_RISE
            && cmdMatch && cmdByte[6] == CMD_READ;
        wrDone = !q.sync.conversion_start_select && sckRise && q.phase == PH_WRITE && q.riseCnt == DATA_LAST_RISE;
        statusWord = {q.cfg.ovIdle, q.cfg.spanEn, q.cfg.hiZEn, q.cfg.relaxedEn, 2'b00};
        popHead = cnvFall & headValid;
    end

    always_comb begin
        d = q;
        d.meta = '{sck: serialClock, conversion_start_select: conversionStartSelect, sdi: serialDataIn,
            ov: overvoltageEvent};
        d.sync = q.meta;
        d.sckPrev = q.sync.sck;
        d.cnvPrev = q.sync.conversion_start_select;
        if (cnvFall) begin
            // Result first, status bits behind it when enabled
            d.outSh = {(headValid ? headData : '0), statusWord, 2'b00};
            d.outLen = q.cfg.statusEn ? LEN_STATUS : LEN_PLAIN;
            d.drive = 1'b1;
            d.riseCnt = '0;
            d.fallCnt = '0;
            d.phase = PH_CMD;
        end else if (cnvRise) begin
            // Frame end also ends a truncated readout
            d.drive = 1'b0;
            d.phase = PH_IDLE;
            if (q.clearPending && !q.sync.ov) begin
                d.cfg.ovIdle = 1'b1;
            end
            d.clearPending = 1'b0;
        end else if (!q.sync.conversion_start_select) begin
            if (sckRise && q.riseCnt <= DATA_LAST_RISE) begin
                d.riseCnt = q.riseCnt + 1'b1;
                case (q.phase)
                    PH_CMD: begin
                        d.cmdSh = cmdByte;
                        if (q.riseCnt == CMD_LAST_RISE) begin
                            if (!cmdMatch) begin
                                d.phase = PH_SKIP;
                            end else if (cmdByte[6] == CMD_READ) begin
                                d.phase = PH_SKIP;
                                d.outSh = {1'b0, q.cfg, (SH_W - 9)'(0)};
                                d.outLen = LEN_REG_FRAME;
                                d.drive = 1'b1;
                                d.clearPending = !q.sync.ov;
                            end else begin
                                d.phase = PH_WRITE;
                            end
                        end
                    end
                    PH_WRITE: begin
                        d.wrSh = wrByte;
                        if (q.riseCnt == DATA_LAST_RISE) begin
                            // Only the writable fields take the byte
                            d.cfg.statusEn = wrByte[BIT_STATUS_EN];
                            d.cfg.spanEn = wrByte[BIT_SPAN_EN];
                            d.cfg.hiZEn = wrByte[BIT_HIZ_EN];
                            d.cfg.relaxedEn = wrByte[BIT_RELAXED_EN];
                            d.phase = PH_SKIP;
                        end
                    end
                    default: begin
                        d.phase = q.phase;
                    end
                endcase
            end
            if (sckFall && q.drive) begin
                d.outSh = {q.outSh[SH_W-2:0], 1'b0};
                d.fallCnt = q.fallCnt + 1'b1;
                if (q.fallCnt + 5'h01 == q.outLen) begin
                    d.drive = 1'b0;
                end
            end
        end
        if (q.sync.ov) begin
            // An event beats a clear in the same cycle
            d.cfg.ovIdle = 1'b0;
            d.clearPending = 1'b0;
        end
        d.cfg.reserved = '0;
        d.sdo = d.outSh[SH_W-1];
        d.oeN = ~d.drive;
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
            q.meta.conversion_start_select <= 1'b1;
            q.sync.conversion_start_select <= 1'b1;
            q.cnvPrev <= 1'b1;
            q.cfg <= CFG_RESET;
            q.phase <= PH_IDLE;
            q.oeN <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign serialDataOut = q.sdo;
    assign serialDataOutOe_n = q.oeN;
    assign statusEnable = q.cfg.statusEn;
    assign spanCompression = q.cfg.spanEn;
    assign highImpedance = q.cfg.hiZEn;
    assign relaxedReadout = q.cfg.relaxedEn;
    assign overvoltageIndicator = q.cfg.ovIdle;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    chk_reserved_zero: assert property (q.cfg.reserved == 3'h0)
        else $error("reserved bits not zero");
    chk_ov_event_sets: assert property (q.sync.ov |=> !q.cfg.ovIdle)
        else $error("overvoltage event not recorded");
    chk_ov_held: assert property (!q.cfg.ovIdle && !cnvRise |=> !q.cfg.ovIdle)
        else $error("indicator left event state outside frame end");
    chk_ov_clear_frame: assert property ($rose(q.cfg.ovIdle) |-> $past(cnvRise))
        else $error("indicator cleared away from frame end");
    chk_write_fields: assert property (wrDone |=> {q.cfg.statusEn, q.cfg.spanEn,
        q.cfg.hiZEn, q.cfg.relaxedEn} == $past(wrByte[4:1]))
        else $error("write byte not applied");
    chk_write_keeps_ov: assert property (wrDone && !q.sync.ov && !q.cfg.ovIdle
        |=> !q.cfg.ovIdle)
        else $error("write changed indicator");
    chk_enables_by_write: assert property (!$stable(q.cfg[4:1]) |-> $past(wrDone))
        else $error("enables changed without a write instruction");
    chk_read_loads_reg: assert property (rdDecode |=> q.outSh[SH_W-2 -: 8] == $past(q.cfg)
        ##1 q.drive)
        else $error("register not loaded for readout");
    chk_frame_length: assert property (cnvFall |=> q.outLen ==
        ($past(q.cfg.statusEn) ? LEN_STATUS : LEN_PLAIN))
        else $error("frame length does not follow status enable");
    chk_status_layout: assert property (cnvFall |=> q.outSh[STATUS_BITS+1:2] ==
        $past(statusWord))
        else $error("status bits misplaced");
    chk_truncate_release: assert property (cnvRise |=> ##1 q.oeN)
        else $error("data pin still driven after frame end");

    cov_status_frame: cover property (cnvFall && q.cfg.statusEn ##[1:400] cnvRise);
    cov_reg_write: cover property (wrDone);
    cov_reg_read_clear: cover property (rdDecode ##[1:400] $rose(q.cfg.ovIdle));

endmodule : adc_config_register_sck_budget

// file: spi_host_model.sv
// Serial host model that opens frames and collects the device's data pin
`timescale 1ns/1ps
module spi_host_model (
    output logic serialClock, // Serial clock, stands low between frames
    output logic conversionStartSelect, // Frame select, low inside a frame
    output logic serialDataIn, // Data to the device
    input wire logic serialDataOut, // Device data pin value
    input wire logic serialDataOutOe_n // Device drive enable, low while driving
);
    // Far slower than the shortest period the device allows
    localparam realtime HALF = 100.0;
    logic lastBit;
    initial begin
        serialClock = 1'h0;
        conversionStartSelect = 1'h1;
        serialDataIn = 1'h1;
        lastBit = 1'h0;
    end
    // Nothing paces conversions here, so no frame length breaks the clock budget
    task automatic frame(
        input logic [15:0] mosi,
        input int edges,
        output logic [21:0] miso
    );
        miso = '0;
        #7;
        conversionStartSelect = 1'h0;
        #300;
        for (int i = 0; i < edges; i++) begin
            serialDataIn = (i < 16) ? mosi[15-i] : 1'h1;
            #HALF;
            serialClock = 1'h1;
            #(HALF - 1.0);
            // A released pin reads as the inverse of its last level
            lastBit = serialDataOutOe_n ? ~lastBit : serialDataOut;
            if (i < 22) miso[21-i] = lastBit;
            #1;
            serialClock = 1'h0;
        end
        #300;
        conversionStartSelect = 1'h1;
        #300;
    endtask : frame
endmodule : spi_host_model

// file: adc_config_register_sck_budget_tb.sv
// Self-checking bench: register access, overvoltage flag and result readout
`timescale 1ns/1ps
module adc_config_register_sck_budget_tb import adc_cfg_pkg::*;;
    logic core_clk, sys_rst, serialClock, conversionStartSelect, serialDataIn;
    logic overvoltageEvent, resultValid, resultReady, serialDataOut, serialDataOutOe_n;
    logic statusEnable, spanCompression, highImpedance, relaxedReadout, overvoltageIndicator;
    logic [15:0] resultData;
    logic [7:0] cfgPorts;
    logic [7:0] mCfg;
    logic [15:0] resQ[$];
    logic [7:0] badCmd [4] = '{8'h94, 8'hD4, 8'h15, 8'h34};
    int errTotal = 0;
    int checked = 0;
    int cycles = 0;
    int seed = 32'h7094E51F;
    assign cfgPorts = {3'h0, statusEnable, spanCompression, highImpedance, relaxedReadout,
        overvoltageIndicator};

    adc_config_register_sck_budget #(.RESULT_W(RESULT_BITS), .DEPTH(FIFO_WORDS)) i_dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .serialClock(serialClock),
        .conversionStartSelect(conversionStartSelect), .serialDataIn(serialDataIn),
        .overvoltageEvent(overvoltageEvent), .resultData(resultData),
        .resultValid(resultValid), .resultReady(resultReady), .serialDataOut(serialDataOut),
        .serialDataOutOe_n(serialDataOutOe_n), .statusEnable(statusEnable),
        .spanCompression(spanCompression), .highImpedance(highImpedance),
        .relaxedReadout(relaxedReadout), .overvoltageIndicator(overvoltageIndicator)
    );
    spi_host_model i_host (
        .serialClock(serialClock), .conversionStartSelect(conversionStartSelect),
        .serialDataIn(serialDataIn), .serialDataOut(serialDataOut),
        .serialDataOutOe_n(serialDataOutOe_n)
    );

    initial begin
        core_clk = 1'h0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic printVerdict();
        $display("Comparisons %0d, mismatches %0d", checked, errTotal);
        if (errTotal == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : printVerdict

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errTotal++;
            $display("BAD %0t run did not finish in time", $time);
            printVerdict();
        end
    end

    task automatic chkFrame(input logic [21:0] got, input logic [21:0] want);
        checked++;
        if (got !== want) begin
            errTotal++;
            $display("BAD %0t frame data %h expected %h", $time, got, want);
        end
    endtask : chkFrame

    task automatic chkPort(input logic [7:0] got, input logic [7:0] want);
        checked++;
        if (got !== want) begin
            errTotal++;
            $display("BAD %0t port value %h expected %h", $time, got, want);
        end
    endtask : chkPort

    function automatic logic [15:0] cmd(input logic rw, input logic [7:0] d);
        return {CMD_REQUEST, rw, CMD_PATTERN, d};
    endfunction : cmd

    // One frame against the model; every frame consumes the oldest stored result
    task automatic runFrame(input logic [15:0] mosi, input int edges);
        logic [21:0] miso, want, mask;
        logic [15:0] res;
        logic good, rd;
        int n;
        res = (resQ.size() > 0) ? resQ.pop_front() : 16'h0000;
        good = ({mosi[15], mosi[13:8]} == {CMD_REQUEST, CMD_PATTERN});
        rd = good && mosi[14] == CMD_READ;
        want = {res, mCfg[0], mCfg[3], mCfg[2], mCfg[1], 2'h0};
        // The read load puts a zero ahead of the register byte on the eighth bit
        if (rd) want[14:6] = {1'h0, mCfg};
        n = (mCfg[4] && !rd) ? 22 : 16;
        n = (edges < n) ? edges : n;
        mask = ~(22'h3FFFFF >> n);
        i_host.frame(mosi, edges, miso);
        if (good && !rd && edges >= 16) mCfg[4:1] = mosi[4:1];
        if (rd && !overvoltageEvent) mCfg[0] = 1'h1;
        chkFrame(miso & mask, want & mask);
        chkPort(cfgPorts, mCfg);
        chkPort({7'h00, serialDataOutOe_n}, 8'h01);
    endtask : runFrame

    task automatic push(input logic [15:0] w);
        logic room;
        repeat (2) @(posedge core_clk);
        #1;
        room = (resQ.size() < FIFO_WORDS);
        chkPort({7'h00, resultReady}, {7'h00, room});
        resultData = w;
        resultValid = 1'h1;
        @(posedge core_clk);
        #1;
        resultValid = 1'h0;
        if (room) resQ.push_back(w);
    endtask : push

    initial begin
        sys_rst = 1'h1;
        overvoltageEvent = 1'h0;
        resultValid = 1'h0;
        resultData = 16'h0000;
        mCfg = CFG_RESET;
        repeat (16) @(posedge core_clk);
        #1;
        sys_rst = 1'h0;
        repeat (4) @(posedge core_clk);
        chkPort(cfgPorts, 8'h01);
        runFrame(cmd(CMD_READ, 8'h00), 16);
        runFrame(cmd(1'h0, 8'hFF), 16);
        runFrame(cmd(CMD_READ, 8'h00), 16);
        for (int k = 0; k < 5; k++) begin
            runFrame(cmd(1'h0, 8'($random(seed))), 16);
            runFrame(cmd(CMD_READ, 8'h00), 16);
        end
        foreach (badCmd[k]) runFrame({badCmd[k], ~mCfg}, 16);
        runFrame(cmd(1'h0, ~mCfg), 15);
        @(posedge core_clk);
        #1;
        overvoltageEvent = 1'h1;
        mCfg[0] = 1'h0;
        repeat (8) @(posedge core_clk);
        chkPort(cfgPorts, mCfg);
        runFrame(cmd(CMD_READ, 8'h00), 16);
        @(posedge core_clk);
        #1;
        overvoltageEvent = 1'h0;
        repeat (8) @(posedge core_clk);
        chkPort(cfgPorts, mCfg);
        runFrame(cmd(CMD_READ, 8'h00), 16);
        runFrame(cmd(1'h0, 8'h1F), 16);
        for (int k = 0; k < 5; k++) push(16'($random(seed)));
        runFrame(16'hFFFF, 22);
        runFrame(16'hFFFF, 18);
        push(16'($random(seed)));
        runFrame(cmd(CMD_READ, 8'h00), 22);
        runFrame(16'hFFFF, 22);
        runFrame(16'hFFFF, 22);
        runFrame(cmd(1'h0, 8'h00), 22);
        runFrame(16'hFFFF, 22);
        printVerdict();
    end
endmodule : adc_config_register_sck_budget_tb
